// File: hdl/epc_scale.sv
/*
  epc_scale: converts native position (65,536 counts per turn) into
  counts at a programmed counts-per-revolution value.
  Assumes the caller registers the result; this module is combinational.
*/
`timescale 1ns/1ps
module epc_scale (
  // native position and scaling setting
  input wire logic [31:0] native_pos,
  input wire logic [16:0] counts_per_revolution,
  input wire logic scale_on,
  // result
  output logic [31:0] scaled_pos
);
  logic [15:0] turns;
  logic [15:0] frac;
  logic [32:0] turn_part;
  logic [32:0] frac_part;

  // whole turns times cpr plus the fractional turn, truncated toward zero
  always_comb begin
    turns = native_pos[31:16];
    frac = native_pos[15:0];
    turn_part = 33'(turns) * 33'(counts_per_revolution);
    frac_part = (33'(frac) * 33'(counts_per_revolution)) >> epc_pkg::NATIVE_FRAC_BITS;
    if (scale_on) begin
      scaled_pos = turn_part[31:0] + frac_part[31:0];
    end else begin
      scaled_pos = native_pos;
    end
  end
endmodule : epc_scale

// File: hdl/epc_top.sv
/*
  epc_top: position and velocity reporting with parameter control for a
  networked absolute rotary encoder; serves the four input words.
  Assumes the sensor position, controller command and configuration writes
  are synchronous to core_clk; the word read port is combinational on addr.
*/
`timescale 1ns/1ps
module epc_top #(
  parameter int unsigned SAMPLE_CYCLES = epc_pkg::SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // sensor
  input wire logic [31:0] native_pos,
  // configuration write
  input wire logic cfg_wr,
  input wire epc_pkg::epc_cfg_s cfg_in,
  // controller command words and sign of life
  input wire epc_pkg::epc_cmd_s cmd_in,
  input wire logic sol_fail,
  // alarm sources
  input wire logic comm_alarm,
  input wire logic encoder_fault,
  // address switches and stored address
  input wire logic [9:0] addr_switch,
  input wire logic [31:0] stored_addr,
  // input word read port
  input wire logic [1:0] rd_addr,
  output logic [15:0] rd_data,
  // status
  output epc_pkg::epc_cfg_s cfg_active,
  output logic handshake_skip,
  output logic alarm_out,
  output logic sol_error,
  output logic preset_done,
  output logic preset_reject,
  output logic [31:0] net_addr
);
  typedef struct packed {
    epc_pkg::epc_cfg_s cfg;
    logic [31:0] offset;
    logic [31:0] pos_word;
    logic [31:0] vel_word;
    logic [31:0] prev_scaled;
    logic [31:0] prev_native;
    logic [3:0] prev_field;
    logic [8:0] sol_cnt;
    logic sol_err;
    logic [31:0] tick_cnt;
    logic strap_done;
    logic addr_dflt;
    logic preset_ok;
    logic preset_bad;
    logic alarm;
  } epc_state_s;

  epc_state_s cur;
  epc_state_s next_cur;

  logic [31:0] dir_pos;
  logic [31:0] scaled_pos;
  logic scale_on;
  logic tick;
  logic fire;
  logic allowed;
  logic [31:0] delta;
  logic [31:0] native_delta;
  logic [63:0] rpm_wide;
  logic [8:0] sol_limit;

  // elaboration check: the sample divider needs at least two cycles
  if (SAMPLE_CYCLES < 2) begin : g_bad_period
    $error("epc_top: SAMPLE_CYCLES must be at least 2");
  end

  // one input word chosen from the latched pair registers
  function automatic logic [15:0] word_sel(input logic [1:0] a, input logic [31:0] p,
                                           input logic [31:0] v);
    case (a)
      epc_pkg::POS_LOW_OFS: word_sel = p[15:0];
      epc_pkg::POS_HIGH_OFS: word_sel = p[31:16];
      epc_pkg::VEL_LOW_OFS: word_sel = v[15:0];
      default: word_sel = v[31:16];
    endcase
  endfunction : word_sel

  // direction applied only with class 4; otherwise clockwise counts up
  assign dir_pos = (cur.cfg.class4_en && cur.cfg.dir_ccw) ? (32'h0 - native_pos)
                                                         : native_pos;
  assign scale_on = cur.cfg.class4_en && cur.cfg.scaling_enable_bit;

  epc_scale u_scale (
    .native_pos(dir_pos),
    .counts_per_revolution(cur.cfg.counts_per_revolution),
    .scale_on(scale_on),
    .scaled_pos(scaled_pos)
  );

  // sampling, preset, sign-of-life and strap logic
  always_comb begin
    next_cur = cur;
    next_cur.preset_ok = 1'b0;
    next_cur.preset_bad = 1'b0;
    tick = (cur.tick_cnt == 32'(SAMPLE_CYCLES - 1));
    delta = scaled_pos - cur.prev_scaled;
    native_delta = dir_pos - cur.prev_native;
    rpm_wide = ($signed(64'(signed'(native_delta))) * $signed(64'(epc_pkg::MS_PER_MIN)))
               >>> epc_pkg::NATIVE_FRAC_BITS;
    // strap caught once, on the first cycle after reset release
    if (!cur.strap_done) begin
      next_cur.strap_done = 1'b1;
      next_cur.addr_dflt = (addr_switch == epc_pkg::ADDR_SWITCH_DEFAULT);
    end
    if (cfg_wr) begin
      next_cur.cfg = cfg_in;
      if (cfg_in.sol_tolerance < epc_pkg::SOL_TOL_MIN) begin
        next_cur.cfg.sol_tolerance = epc_pkg::SOL_TOL_MIN;
      end
    end
    // divider and simultaneous capture of both words; halves never split
    next_cur.tick_cnt = tick ? 32'h0 : cur.tick_cnt + 32'h1;
    if (tick) begin
      next_cur.prev_scaled = scaled_pos;
      next_cur.prev_native = dir_pos;
      next_cur.pos_word = scaled_pos + cur.offset;
      case (cur.cfg.vel_format)
        epc_pkg::VEL_PER_MS: next_cur.vel_word = delta;
        epc_pkg::VEL_PER_MIN: next_cur.vel_word = 32'(delta * epc_pkg::MS_PER_MIN);
        epc_pkg::VEL_RPM: next_cur.vel_word = rpm_wide[31:0];
        default: next_cur.vel_word = 32'(delta * epc_pkg::MS_PER_SEC);
      endcase
    end
    // preset on the 0x2 to 0xD move of the apply-preset field
    next_cur.prev_field = cmd_in.command_word[epc_pkg::PRESET_FIELD_LSB +: 4];
    fire = (cur.prev_field == epc_pkg::PRESET_ARM_CODE) &&
           (cmd_in.command_word[epc_pkg::PRESET_FIELD_LSB +: 4] ==
            epc_pkg::PRESET_FIRE_CODE);
    allowed = cur.cfg.class4_en && (cmd_in.preset_signal != 2'h0 || cur.cfg.preset1_en) &&
              (cur.cfg.total_range_counts == 32'h0 ||
               cmd_in.preset_value <= cur.cfg.total_range_counts);
    if (fire) begin
      if (allowed) begin
        next_cur.offset = cmd_in.preset_value - scaled_pos;
        next_cur.preset_ok = 1'b1;
      end else begin
        next_cur.preset_bad = 1'b1;
      end
    end
    // sign-of-life: tolerance only counts in compatibility mode
    sol_limit = cur.cfg.compat_mode ? {1'b0, cur.cfg.sol_tolerance} : 9'h000;
    if (sol_fail && cur.sol_cnt != 9'h1FF) begin
      next_cur.sol_cnt = cur.sol_cnt + 9'h001;
    end
    if (next_cur.sol_cnt > sol_limit) begin
      next_cur.sol_err = 1'b1;
    end
    // alarm channel content
    next_cur.alarm = comm_alarm ||
                     (encoder_fault && (!cur.cfg.compat_mode || cur.cfg.alarm_ctrl));
  end

  // state register with factory defaults
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur <= '0;
      cur.cfg <= epc_pkg::CFG_DEFAULT;
      cur.offset <= epc_pkg::DFLT_OFFSET;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs
  assign rd_data = word_sel(rd_addr, cur.pos_word, cur.vel_word);
  assign cfg_active = cur.cfg;
  assign handshake_skip = cur.cfg.compat_mode;
  assign alarm_out = cur.alarm;
  assign sol_error = cur.sol_err;
  assign preset_done = cur.preset_ok;
  assign preset_reject = cur.preset_bad;
  assign net_addr = cur.addr_dflt ? epc_pkg::DEFAULT_NET_ADDR : stored_addr;

  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  words_paired_a: assert property ($changed(cur.pos_word) |-> $past(tick))
    else $error("position word changed outside a sample");
  low_word_a: assert property (rd_addr == 2'h0 |-> rd_data == cur.pos_word[15:0])
    else $error("position low word misplaced");
  vel_high_a: assert property (rd_addr == 2'h3 |-> rd_data == cur.vel_word[31:16])
    else $error("velocity high word misplaced");
  preset_fire_a: assert property (fire && allowed |=> preset_done ##0
                                  scaled_pos + cur.offset == $past(cmd_in.preset_value)
                                  || $changed(native_pos) || $past(cfg_wr))
    else $error("preset did not land on preset value");
  class4_reject_a: assert property (fire && !cur.cfg.class4_en |=> preset_reject)
    else $error("preset accepted without class 4");
  signal_one_a: assert property (fire && cmd_in.preset_signal == 2'h0
                                 && !cur.cfg.preset1_en |=> !preset_done)
    else $error("signal one preset while forbidden");
  no_fire_a: assert property (preset_done |-> $past(cur.prev_field) == 4'h2)
    else $error("preset without arm code");
  sol_single_a: assert property (!cur.cfg.compat_mode && sol_fail && !cfg_wr
                                 |=> sol_error)
    else $error("single sign-of-life failure not flagged");
  sol_tol_a: assert property (cur.cfg.compat_mode && cur.sol_cnt <= {1'b0,
                              cur.cfg.sol_tolerance} |-> !cur.sol_err || $past(cur.sol_err)
                              || $past(!cur.cfg.compat_mode))
    else $error("sign-of-life error before tolerance exceeded");
  alarm_mask_a: assert property (cur.cfg.compat_mode && !cur.cfg.alarm_ctrl && !comm_alarm
                                 && !cfg_wr |=> !alarm_out)
    else $error("encoder fault sent on alarm channel");
  scale_off_a: assert property (!cur.cfg.class4_en |-> scaled_pos == native_pos)
    else $error("class 4 off did not force native counts");
  handshake_a: assert property (handshake_skip == cur.cfg.compat_mode)
    else $error("handshake skip mismatch");

  preset_c: cover property (fire ##1 preset_done);
  reject_c: cover property (fire ##1 preset_reject);
  sol_err_c: cover property (cur.cfg.compat_mode && sol_fail ##1 sol_error);
  sample_c: cover property (tick ##1 $changed(cur.vel_word));
endmodule : epc_top

// File: pkg/epc_pkg.sv
/*
  epc_pkg: constants, defaults and carrier types for the encoder position,
  velocity and parameter control block.
  Assumes a single 100 MHz core clock and synchronous active-high reset.
*/
package epc_pkg;
  // clock and sampling
  localparam int unsigned CLK_PERIOD_PS = 10_000;
  localparam int unsigned SAMPLE_PERIOD_NS = 1_000_000;
  localparam int unsigned SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  // input register map (word offsets)
  localparam logic [1:0] POS_LOW_OFS = 2'h0;
  localparam logic [1:0] POS_HIGH_OFS = 2'h1;
  localparam logic [1:0] VEL_LOW_OFS = 2'h2;
  localparam logic [1:0] VEL_HIGH_OFS = 2'h3;

  // command word: apply-preset field position and transition codes
  localparam int unsigned PRESET_FIELD_LSB = 0;
  localparam logic [3:0] PRESET_ARM_CODE = 4'h2;
  localparam logic [3:0] PRESET_FIRE_CODE = 4'hD;

  // velocity format codes
  localparam logic [15:0] VEL_PER_SEC = 16'h1F04;
  localparam logic [15:0] VEL_PER_MS = 16'h1F05;
  localparam logic [15:0] VEL_PER_MIN = 16'h1F07;
  localparam logic [15:0] VEL_RPM = 16'h1F0F;
  localparam logic [31:0] MS_PER_SEC = 32'h0000_03E8;
  localparam logic [31:0] MS_PER_MIN = 32'h0000_EA60;

  // resolution
  localparam int unsigned NATIVE_FRAC_BITS = 16;
  localparam logic [16:0] NATIVE_CPR = 17'h1_0000;

  // address switches
  localparam logic [9:0] ADDR_SWITCH_DEFAULT = 10'h3E7;
  localparam logic [31:0] DEFAULT_NET_ADDR = 32'hC0A8_0032;

  // sign-of-life tolerance lower bound
  localparam logic [7:0] SOL_TOL_MIN = 8'h01;

  // factory defaults
  localparam logic DFLT_COMPAT = 1'b0;
  localparam logic DFLT_CLASS4 = 1'b1;
  localparam logic DFLT_DIR_CCW = 1'b0;
  localparam logic DFLT_SCALE_EN = 1'b0;
  localparam logic DFLT_PRESET1_EN = 1'b0;
  localparam logic DFLT_ALARM_CTRL = 1'b0;
  localparam logic [7:0] DFLT_SOL_TOL = 8'h01;
  localparam logic [16:0] DFLT_CPR = 17'h1_0000;
  localparam logic [31:0] DFLT_TMR = 32'h0000_0000;
  localparam logic [15:0] DFLT_VEL_FMT = 16'h1F04;
  localparam logic [31:0] DFLT_OFFSET = 32'h0000_0000;

  // parameter set
  typedef struct packed {
    logic compat_mode;
    logic class4_en;
    logic dir_ccw;
    logic scaling_enable_bit;
    logic preset1_en;
    logic alarm_ctrl;
    logic [7:0] sol_tolerance;
    logic [16:0] counts_per_revolution;
    logic [31:0] total_range_counts;
    logic [15:0] vel_format;
  } epc_cfg_s;

  localparam epc_cfg_s CFG_DEFAULT = '{
    compat_mode: DFLT_COMPAT, class4_en: DFLT_CLASS4, dir_ccw: DFLT_DIR_CCW,
    scaling_enable_bit: DFLT_SCALE_EN, preset1_en: DFLT_PRESET1_EN,
    alarm_ctrl: DFLT_ALARM_CTRL, sol_tolerance: DFLT_SOL_TOL,
    counts_per_revolution: DFLT_CPR, total_range_counts: DFLT_TMR,
    vel_format: DFLT_VEL_FMT};

  // controller command group
  typedef struct packed {
    logic [15:0] command_word;
    logic [31:0] preset_value;
    logic [1:0] preset_signal;
  } epc_cmd_s;
endpackage : epc_pkg

// File: test/epc_ctrl_model.sv
/*
  epc_ctrl_model: network controller side, issues the apply-preset sequence.
  Assumes go is a one-cycle pulse synchronous to core_clk.
*/
`timescale 1ns/1ps
module epc_ctrl_model (
  // clock and request from the bench
  input wire logic core_clk,
  input wire logic go,
  input wire logic [31:0] value,
  input wire logic [1:0] sig,
  // command words toward the block
  output epc_pkg::epc_cmd_s cmd
);
  logic [1:0] step;
  initial begin
    cmd = '0;
    step = 2'h0;
  end
  // arm code held two cycles so the fire code always follows a settled arm
  always @(posedge core_clk) begin
    if (go) begin
      cmd <= '{{12'h000, epc_pkg::PRESET_ARM_CODE}, value, sig};
      step <= 2'h1;
    end else if (step == 2'h1) begin
      step <= 2'h2;
    end else if (step == 2'h2) begin
      cmd.command_word <= {12'h000, epc_pkg::PRESET_FIRE_CODE};
      step <= 2'h3;
    end else if (step == 2'h3) begin
      // released value scrambled so the block cannot lean on a stale word
      cmd.command_word <= 16'h0000;
      cmd.preset_value <= ~cmd.preset_value;
      step <= 2'h0;
    end
  end
endmodule : epc_ctrl_model

// File: test/tb_epc_top.sv
/*
  tb_epc_top: self-checking bench for epc_top with a controller model.
  Assumes SAMPLE_CYCLES of 8; address switches at 999 until the scaling
  scenario moves them off, so the stored address path is seen as well.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); end end
module tb_epc_top;
  localparam int unsigned SC = 8;
  logic core_clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, sol_fail = 1'b0;
  logic comm_alarm = 1'b0, encoder_fault = 1'b0, go = 1'b0, ramp = 1'b0;
  logic [31:0] native_pos = 32'h050D_1341, pv = 32'h0, stored_addr = 32'h0A00_0001;
  logic [1:0] rd_addr = 2'h0, psig = 2'h0;
  logic [9:0] addr_switch = 10'h3E7;
  epc_pkg::epc_cfg_s cfg_in = epc_pkg::CFG_DEFAULT, cfg_active, c;
  epc_pkg::epc_cmd_s cmd_in;
  logic [15:0] rd_data;
  logic [31:0] net_addr, w;
  logic handshake_skip, alarm_out, sol_error, preset_done, preset_reject;
  int num_errors = 0, check_count = 0;
  epc_top #(.SAMPLE_CYCLES(SC)) DUT (.core_clk(core_clk), .rst(rst), .native_pos(native_pos),
    .cfg_wr(cfg_wr), .cfg_in(cfg_in), .cmd_in(cmd_in), .sol_fail(sol_fail),
    .comm_alarm(comm_alarm), .encoder_fault(encoder_fault), .addr_switch(addr_switch),
    .stored_addr(stored_addr), .rd_addr(rd_addr), .rd_data(rd_data),
    .cfg_active(cfg_active), .handshake_skip(handshake_skip), .alarm_out(alarm_out),
    .sol_error(sol_error), .preset_done(preset_done), .preset_reject(preset_reject),
    .net_addr(net_addr));
  epc_ctrl_model ctrl (.core_clk(core_clk), .go(go), .value(pv), .sig(psig), .cmd(cmd_in));
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  // steady shaft motion, one count per cycle
  always @(posedge core_clk) if (ramp) native_pos <= native_pos + 32'h1;
  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic do_reset();
    @(posedge core_clk) rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
  endtask : do_reset
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic set_cfg(input epc_pkg::epc_cfg_s v);
    @(posedge core_clk) cfg_in <= v;
    cfg_wr <= 1'b1;
    @(posedge core_clk) cfg_wr <= 1'b0;
  endtask : set_cfg
  // both halves read back to back; the pair must come from one sample
  task automatic rd32(input logic [1:0] base, output logic [31:0] v);
    @(posedge core_clk) rd_addr <= base;
    cyc(1);
    v[15:0] = rd_data;
    rd_addr <= base + 2'h1;
    #1 v[31:16] = rd_data;
  endtask : rd32
  task automatic pulse_sol();
    @(posedge core_clk) sol_fail <= 1'b1;
    @(posedge core_clk) sol_fail <= 1'b0;
    cyc(2);
  endtask : pulse_sol
  task automatic preset(input logic [31:0] v, input logic [1:0] s, input logic ok);
    int k;
    pv = v;
    psig = s;
    @(posedge core_clk) go <= 1'b1;
    @(posedge core_clk) go <= 1'b0;
    for (k = 0; k < 10 && preset_done !== 1'b1 && preset_reject !== 1'b1; k++) cyc(1);
    if (k == 10) begin
      num_errors++;
      conclude();
    end
    `CHK("preset_done", ok, preset_done)
  endtask : preset
  task automatic t_defaults();
    cyc(2 * SC + 2);
    `CHK("cfg_active", epc_pkg::CFG_DEFAULT, cfg_active)
    `CHK("net_addr", epc_pkg::DEFAULT_NET_ADDR, net_addr)
    rd32(2'h0, w);
    `CHK("position", 32'h050D_1341, w)
  endtask : t_defaults
  task automatic t_velocity();
    logic [15:0] fmt [4] = '{16'h1F04, 16'h1F05, 16'h1F07, 16'h1F0F};
    logic [31:0] ex [4] = '{32'h0000_1F40, 32'h0000_0008, 32'h0007_5300, 32'h0000_0007};
    ramp <= 1'b1;
    c = epc_pkg::CFG_DEFAULT;
    for (int i = 0; i < 4; i++) begin
      c.vel_format = fmt[i];
      set_cfg(c);
      cyc(3 * SC);
      rd32(2'h2, w);
      `CHK("velocity", ex[i], w)
    end
    ramp <= 1'b0;
  endtask : t_velocity
  task automatic t_scaling();
    addr_switch <= 10'h000;
    do_reset();
    cyc(1);
    `CHK("net_addr stored", stored_addr, net_addr)
    native_pos <= 32'h0002_0000;
    c = epc_pkg::CFG_DEFAULT;
    c.scaling_enable_bit = 1'b1;
    c.counts_per_revolution = 17'h0_8000;
    set_cfg(c);
    cyc(2 * SC + 2);
    rd32(2'h0, w);
    `CHK("scaled position", 32'h0001_0000, w)
    c.class4_en = 1'b0;
    c.dir_ccw = 1'b1;
    set_cfg(c);
    cyc(2 * SC + 2);
    rd32(2'h0, w);
    `CHK("class4 off position", 32'h0002_0000, w)
  endtask : t_scaling
  task automatic t_preset();
    do_reset();
    native_pos <= 32'h0001_0005;
    preset(32'h0000_1234, 2'h0, 1'b0);
    preset(32'h0000_1234, 2'h1, 1'b1);
    cyc(2 * SC + 2);
    rd32(2'h0, w);
    `CHK("preset position", 32'h0000_1234, w)
    // a preset beyond a set total range must be refused
    c = epc_pkg::CFG_DEFAULT;
    c.total_range_counts = 32'h0000_1000;
    set_cfg(c);
    preset(32'h0000_2000, 2'h1, 1'b0);
    c = epc_pkg::CFG_DEFAULT;
    c.class4_en = 1'b0;
    c.preset1_en = 1'b1;
    set_cfg(c);
    preset(32'h0000_0777, 2'h2, 1'b0);
    preset(32'h0000_0777, 2'h0, 1'b0);
  endtask : t_preset
  task automatic t_sol_alarm();
    do_reset();
    pulse_sol();
    `CHK("sol_error single", 1'b1, sol_error)
    do_reset();
    c = epc_pkg::CFG_DEFAULT;
    c.compat_mode = 1'b1;
    c.sol_tolerance = 8'h02;
    set_cfg(c);
    cyc(1);
    `CHK("handshake_skip", 1'b1, handshake_skip)
    pulse_sol();
    pulse_sol();
    `CHK("sol_error within", 1'b0, sol_error)
    pulse_sol();
    `CHK("sol_error beyond", 1'b1, sol_error)
    encoder_fault <= 1'b1;
    cyc(3);
    `CHK("fault masked", 1'b0, alarm_out)
    comm_alarm <= 1'b1;
    cyc(3);
    `CHK("comm alarm", 1'b1, alarm_out)
    comm_alarm <= 1'b0;
    c.alarm_ctrl = 1'b1;
    set_cfg(c);
    cyc(3);
    `CHK("fault passed", 1'b1, alarm_out)
    encoder_fault <= 1'b0;
  endtask : t_sol_alarm
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_defaults();
    t_velocity();
    t_scaling();
    t_preset();
    t_sol_alarm();
    conclude();
  end
endmodule : tb_epc_top
